// ---- ipr_arbiter.sv ----
`timescale 1ns/100ps
`default_nettype none
// picks the pending source with the highest nonzero priority code
module ipr_arbiter #(
  parameter int N = ipr_pkg::NUM_SRC
) (
  input  wire logic [N-1:0]   pending,
  input  wire logic [N*3-1:0] levels,
  output logic                win_valid,
  output logic [2:0]          win_id,
  output logic [2:0]          win_level
);

  // higher code wins; equal codes go to the lower source number
  always_comb begin
    win_valid = 1'b0;
    win_id    = 3'h0;
    win_level = ipr_pkg::PRIO_OFF;
    for (int i = 0; i < N; i++) begin
      // code 000 never competes
      if (pending[i] && (levels[i*3 +: 3] != ipr_pkg::PRIO_OFF)) begin // RULE_03
        // unsigned compare makes 111 top and 001 bottom
        if (!win_valid || (levels[i*3 +: 3] > win_level)) begin // RULE_01 RULE_02
          win_valid = 1'b1;
          win_id    = i[2:0];
          win_level = levels[i*3 +: 3];
        end
      end
    end
  end

endmodule : ipr_arbiter
`default_nettype wire

// ---- ipr_field_reg.sv ----
`timescale 1ns/100ps
`default_nettype none
// one three-bit priority field with its reset code
module ipr_field_reg #(
  parameter logic [2:0] RESET_CODE = ipr_pkg::PRIO_RESET
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_data,
  output var  logic [2:0] q
);

  // field storage, loaded by software, reset to the default level
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_CODE; // RULE_05
    end else if (wr_en) begin
      q <= wr_data;
    end
  end

endmodule : ipr_field_reg
`default_nettype wire

// ---- ipr_interrupt_priority_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// two priority control registers and the arbitration they steer
module ipr_interrupt_priority_regs #(
  parameter int NUM_SRC = ipr_pkg::NUM_SRC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  // plain register port
  input  wire logic [3:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [15:0]              reg_rdata,
  // interrupt side
  input  wire logic [NUM_SRC-1:0]  src_pending,
  input  wire logic [2:0]          cpu_level,
  input  wire logic                irq_ack,
  output logic                     irq_request,
  output logic [2:0]               irq_source,
  output logic [2:0]               irq_level,
  // field values for the rest of the controller
  output logic [NUM_SRC*3-1:0]     priority_levels
);

  // ------------------------------------------------------------------
  // field storage
  // ------------------------------------------------------------------

  logic [NUM_SRC*3-1:0] prio_q;          // all fields, three bits per source
  logic [NUM_SRC-1:0]   field_wr;        // per-field write enable

  // decode of the two writable registers and the status word
  logic                 hit_three;       // address selects register three
  logic                 hit_four;        // address selects register four
  logic                 hit_status;      // address selects status

  assign hit_three  = (reg_addr == ipr_pkg::OFF_THREE);
  assign hit_four   = (reg_addr == ipr_pkg::OFF_FOUR);
  assign hit_status = (reg_addr == ipr_pkg::OFF_STATUS);

  // one field register per source, placed by the package tables
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_field
    // lsb of this source's field in its register
    localparam int LSB = int'(ipr_pkg::SRC_LSB[i*4 +: 4]);
    // which register this field sits in
    localparam bit IN_FOUR = ipr_pkg::SRC_IN_FOUR[i];

    // write only the three implemented bits of the field
    if (IN_FOUR) begin : g_four
      // pin change, comparator, two-wire master and slave fields
      assign field_wr[i] = reg_wr && hit_four; // RULE_06 RULE_07 RULE_08 RULE_09
    end else begin : g_three
      // memory, converter and serial transmitter fields
      assign field_wr[i] = reg_wr && hit_three; // RULE_10
    end

    ipr_field_reg #(
      .RESET_CODE (ipr_pkg::PRIO_RESET)
    ) u_field (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (field_wr[i]),
      .wr_data (reg_wdata[LSB +: 3]),
      .q       (prio_q[i*3 +: 3])
    );
  end

  // fields go straight out, they are flip-flops already
  assign priority_levels = prio_q;

  // ------------------------------------------------------------------
  // register images for readback
  // ------------------------------------------------------------------

  logic [15:0] img_three;                // assembled register three
  logic [15:0] img_four;                 // assembled register four
  logic [15:0] img_status;               // assembled status word

  // place each field at its bit position, all other bits zero
  always_comb begin
    img_three = 16'h0000;
    img_four  = 16'h0000;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (ipr_pkg::SRC_IN_FOUR[i]) begin
        // register four holds four fields
        img_four[ipr_pkg::SRC_LSB[i*4 +: 4] +: 3] = prio_q[i*3 +: 3]; // RULE_06 RULE_07 RULE_08 RULE_09
      end else begin
        // register three holds three fields
        img_three[ipr_pkg::SRC_LSB[i*4 +: 4] +: 3] = prio_q[i*3 +: 3]; // RULE_10
      end
    end
    // force the unimplemented positions to zero
    img_three = img_three & ipr_pkg::MASK_THREE; // RULE_04
    img_four  = img_four & ipr_pkg::MASK_FOUR; // RULE_04
  end

  // ------------------------------------------------------------------
  // arbitration among pending sources
  // ------------------------------------------------------------------

  logic       win_valid;                 // some enabled source is pending
  logic [2:0] win_id;                    // its source number
  logic [2:0] win_level;                 // its priority code

  ipr_arbiter #(
    .N (NUM_SRC)
  ) u_arb (
    .pending   (src_pending),
    .levels    (prio_q),
    .win_valid (win_valid),
    .win_id    (win_id),
    .win_level (win_level)
  );

  // the winner beats the level the processor already runs at
  logic win_takes;                       // winner may be offered now

  assign win_takes = win_valid && (win_level > cpu_level); // RULE_01 RULE_02

  // ------------------------------------------------------------------
  // offer state machine
  // ------------------------------------------------------------------

  ipr_pkg::ipr_state_e state;            // current offer phase
  ipr_pkg::ipr_state_e next_state;       // phase for the next cycle
  logic [2:0]          offer_src;        // source held while offered
  logic [2:0]          offer_lvl;        // level held while offered

  // next phase: offer a winner, hold it until the processor takes it
  always_comb begin
    next_state = state;
    case (state)
      ipr_pkg::ST_IDLE: begin
        // a disabled or outranked source never leaves idle
        if (win_takes) begin // RULE_03
          next_state = ipr_pkg::ST_OFFER;
        end
      end
      ipr_pkg::ST_OFFER: begin
        // acknowledge frees the way for the next winner
        if (irq_ack) begin
          next_state = ipr_pkg::ST_IDLE;
        end
      end
      default: begin
        // illegal code, fall back to idle
        next_state = ipr_pkg::ST_IDLE;
      end
    endcase
  end

  // phase register
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ipr_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // winner captured on entry to the offer phase, held while offered
  always_ff @(posedge clk) begin
    if (rst) begin
      offer_src <= 3'h0;
      offer_lvl <= ipr_pkg::PRIO_OFF;
    end else if ((state == ipr_pkg::ST_IDLE) && win_takes) begin
      offer_src <= win_id;
      offer_lvl <= win_level; // RULE_01 RULE_02
    end
  end

  // offer outputs; level and source come from flip-flops
  assign irq_request = (state == ipr_pkg::ST_OFFER);
  assign irq_source  = offer_src;
  assign irq_level   = offer_lvl;

  // ------------------------------------------------------------------
  // readback
  // ------------------------------------------------------------------

  // status word: offer flag, offered level and source
  always_comb begin
    img_status                         = 16'h0000;
    img_status[ipr_pkg::STAT_REQ]      = irq_request;
    img_status[ipr_pkg::STAT_LVL +: 3] = offer_lvl;
    img_status[ipr_pkg::STAT_SRC +: 3] = offer_src;
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && hit_three) begin
      reg_rdata <= img_three; // RULE_10
    end else if (reg_rd && hit_four) begin
      reg_rdata <= img_four; // RULE_06 RULE_07 RULE_08 RULE_09
    end else if (reg_rd && hit_status) begin
      reg_rdata <= img_status;
    end else begin
      // no read or unused address reads zero
      reg_rdata <= 16'h0000; // RULE_04
    end
  end

endmodule : ipr_interrupt_priority_regs
`default_nettype wire

// ---- ipr_interrupt_priority_regs_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// watches register port and field outputs of the priority block
module ipr_regs_checker #(
  parameter int NUM_SRC = ipr_pkg::NUM_SRC
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic [3:0]           reg_addr,
  input wire logic [15:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [15:0]          reg_rdata,
  input wire logic                 irq_request,
  input wire logic [2:0]           irq_level,
  input wire logic [NUM_SRC*3-1:0] priority_levels
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // register images rebuilt from the field outputs
  wire logic [15:0] img_three = {1'h0, priority_levels[2:0], 5'h00, priority_levels[5:3],
                                 1'h0, priority_levels[8:6]};
  wire logic [15:0] img_four  = {1'h0, priority_levels[11:9], 1'h0, priority_levels[14:12],
                                 1'h0, priority_levels[17:15], 1'h0, priority_levels[20:18]};
  wire logic        rd3 = reg_rd && reg_addr == ipr_pkg::OFF_THREE;
  wire logic        rd4 = reg_rd && reg_addr == ipr_pkg::OFF_FOUR;
  property p_reset_code; $fell(rst) |-> priority_levels == {7{3'h4}}; endproperty
  a_reset_code: assert property (p_reset_code) else $error("fields not at reset code");
  property p_unimpl; rd3 |=> (reg_rdata & ~ipr_pkg::MASK_THREE) == 16'h0000; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read as one");
  property p_read_three; rd3 |=> reg_rdata == img_three; endproperty
  a_read_three: assert property (p_read_three) else $error("register three read wrong");
  property p_read_four; rd4 |=> reg_rdata == img_four; endproperty
  a_read_four: assert property (p_read_four) else $error("register four read wrong");
  property p_write_four;
    reg_wr && reg_addr == ipr_pkg::OFF_FOUR |=> img_four == ($past(reg_wdata) & 16'h7777);
  endproperty
  a_write_four: assert property (p_write_four) else $error("register four write lost");
  property p_write_three;
    reg_wr && reg_addr == ipr_pkg::OFF_THREE |=> img_three == ($past(reg_wdata) & 16'h7077);
  endproperty
  a_write_three: assert property (p_write_three) else $error("register three write lost");
  property p_hold; !reg_wr |=> $stable(priority_levels); endproperty
  a_hold: assert property (p_hold) else $error("fields changed without a write");
  property p_no_off; irq_request |-> irq_level != 3'h0; endproperty
  a_no_off: assert property (p_no_off) else $error("disabled level offered");
  c_write_four: cover property (reg_wr && reg_addr == ipr_pkg::OFF_FOUR);
  c_read_three: cover property (rd3);
  c_request: cover property (irq_request && irq_level == 3'h7);
endmodule : ipr_regs_checker
bind ipr_interrupt_priority_regs ipr_regs_checker #(.NUM_SRC(NUM_SRC)) u_chk (.clk(clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq_request(irq_request), .irq_level(irq_level),
  .priority_levels(priority_levels));
`default_nettype wire

// ---- ipr_interrupt_priority_regs_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module ipr_interrupt_priority_regs_test;
  logic        clk = 1'b0;           // 50 MHz clock
  logic        rst = 1'b1;           // synchronous reset
  logic [3:0]  reg_addr = 4'h0;      // register index
  logic [15:0] reg_wdata = 16'h0000; // write data
  logic        reg_wr = 1'b0;        // write strobe
  logic        reg_rd = 1'b0;        // read strobe
  logic [15:0] reg_rdata;            // read data
  logic [6:0]  src_pending = 7'h00;  // source flags
  logic        irq_ack = 1'b0;       // cpu accepts offer
  logic [2:0]  cpu_level = 3'h0;     // level the cpu runs at
  logic [20:0] prio_lv;              // field outputs
  logic        irq_request;          // offer valid
  logic [2:0]  irq_source;           // offered source
  logic [2:0]  irq_level;            // offered level
  int          bad_count = 0;        // mismatches
  int          total_checks = 0;     // comparisons
  always #10 clk = ~clk;
  ipr_interrupt_priority_regs DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_pending(src_pending), .cpu_level(cpu_level), .irq_ack(irq_ack),
    .irq_request(irq_request), .irq_source(irq_source), .irq_level(irq_level),
    .priority_levels(prio_lv));
  // one comparison with its report
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(logic [3:0] a, logic [15:0] exp, string what);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask : rd
  // raise flags, wait bounded for an offer, then retire it
  task automatic offer(logic [6:0] p, logic req, logic [2:0] src, logic [2:0] lvl);
    src_pending <= p;
    for (int i = 0; i < 20 && irq_request !== 1'b1; i++) @(posedge clk) #1;
    chk("irq_request", {15'h0000, req}, {15'h0000, irq_request});
    if (req) chk("irq_source", {13'h0000, src}, {13'h0000, irq_source});
    if (req) chk("irq_level", {13'h0000, lvl}, {13'h0000, irq_level});
    @(posedge clk);
    src_pending <= 7'h00; irq_ack <= req;
    @(posedge clk);
    irq_ack <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : offer
  // register images after reset
  task automatic t_reset;
    rd(ipr_pkg::OFF_THREE, 16'h4044, "three reset");
    rd(ipr_pkg::OFF_FOUR, 16'h4444, "four reset");
    chk("levels lo", 16'h4924, prio_lv[15:0]);
    chk("levels hi", 16'h0012, {11'h000, prio_lv[20:16]});
  endtask : t_reset
  // a source must outrank the running cpu level
  task automatic t_level;
    cpu_level <= 3'h3;
    offer(7'h40, 1'b0, 3'h0, 3'h0);
    offer(7'h48, 1'b1, ipr_pkg::SRC_PIN, 3'h7);
    cpu_level <= 3'h0;
  endtask : t_level
  // all ones written, only implemented bits stick
  task automatic t_unimpl;
    wr(ipr_pkg::OFF_THREE, 16'hFFFF);
    rd(ipr_pkg::OFF_THREE, 16'h7077, "three mask");
    wr(ipr_pkg::OFF_FOUR, 16'hFFFF);
    rd(ipr_pkg::OFF_FOUR, 16'h7777, "four mask");
    wr(ipr_pkg::OFF_THREE, 16'h2016);
    rd(ipr_pkg::OFF_THREE, 16'h2016, "three fields");
    wr(ipr_pkg::OFF_FOUR, 16'h1357);
    rd(ipr_pkg::OFF_FOUR, 16'h1357, "four fields");
  endtask : t_unimpl
  // arbitration by code: seven wins, one still offered, zero never
  task automatic t_arb;
    wr(ipr_pkg::OFF_THREE, 16'h0000);
    wr(ipr_pkg::OFF_FOUR, 16'h7103);
    offer(7'h38, 1'b1, ipr_pkg::SRC_PIN, 3'h7);
    offer(7'h10, 1'b1, ipr_pkg::SRC_CMP, 3'h1);
    offer(7'h27, 1'b0, 3'h0, 3'h0);
    offer(7'h40, 1'b1, ipr_pkg::SRC_TWS, 3'h3);
  endtask : t_arb
  // single place where the run ends
  task automatic give_verdict;
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_unimpl();
    t_arb();
    t_level();
    give_verdict();
  end
  // hang guard
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule : ipr_interrupt_priority_regs_test
`default_nettype wire

// ---- ipr_pkg.sv ----
// Operation
// [RULE_01] code 111 is priority seven, highest
// [RULE_02] code 001 is lowest level; codes map linearly
// [RULE_03] code 000 disables the source entirely
// [RULE_04] unimplemented bits read zero, writes ignored
// [RULE_05] every field resets to binary 100
// [RULE_06] pin change priority in register four 14:12
// [RULE_07] comparator priority in register four 10:8
// [RULE_08] two-wire master priority in four 6:4
// [RULE_09] two-wire slave priority in four 2:0
// [RULE_10] register three: memory, converter, serial fields
`default_nettype none
package ipr_pkg;

  // bus geometry
  localparam int          ADDR_W     = 4;                 // register address width
  localparam int          DATA_W     = 16;                // register data width
  localparam int          PRIO_W     = 3;                 // width of one priority field
  localparam int          NUM_SRC    = 7;                 // sources covered by this block
  localparam int          SRC_ID_W   = 3;                 // width of a source number

  // register offsets (word index on the plain port)
  localparam logic [3:0]  OFF_THREE  = 4'h0;              // priority_ctrl_three
  localparam logic [3:0]  OFF_FOUR   = 4'h1;              // priority_ctrl_four
  localparam logic [3:0]  OFF_STATUS = 4'h2;              // arbitration status, read only

  // priority codes
  localparam logic [2:0]  PRIO_OFF   = 3'h0;              // source disabled
  localparam logic [2:0]  PRIO_MIN   = 3'h1;              // lowest enabled level
  localparam logic [2:0]  PRIO_MAX   = 3'h7;              // highest level
  localparam logic [2:0]  PRIO_RESET = 3'h4;              // level after reset

  // source numbering
  localparam logic [2:0]  SRC_NVM    = 3'h0;              // nonvolatile memory
  localparam logic [2:0]  SRC_CONV   = 3'h1;              // analog converter
  localparam logic [2:0]  SRC_STX    = 3'h2;              // first serial transmitter
  localparam logic [2:0]  SRC_PIN    = 3'h3;              // input change notification
  localparam logic [2:0]  SRC_CMP    = 3'h4;              // comparator
  localparam logic [2:0]  SRC_TWM    = 3'h5;              // two-wire master event
  localparam logic [2:0]  SRC_TWS    = 3'h6;              // two-wire slave event

  // per source: 1 = field lives in register four, 0 = register three
  localparam logic [6:0]  SRC_IN_FOUR = 7'h78;
  // per source: lsb of its field, four bits per source, source 0 lowest
  localparam logic [27:0] SRC_LSB    = {4'h0, 4'h4, 4'h8, 4'hC, 4'h0, 4'h4, 4'hC};

  // implemented bits of each register
  localparam logic [15:0] MASK_THREE = 16'h7077;
  localparam logic [15:0] MASK_FOUR  = 16'h7777;

  // status register layout
  localparam int          STAT_REQ   = 15;                // request offered bit
  localparam int          STAT_LVL   = 4;                 // lsb of offered level
  localparam int          STAT_SRC   = 0;                 // lsb of offered source

  // offer state machine, one-hot
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_OFFER = 2'b10
  } ipr_state_e;

endpackage : ipr_pkg
`default_nettype wire
